// [holdover_pkg.sv]
package holdover_pkg;
	// Widths
	localparam int EXP_W = 3;
	localparam int CNT_W = 8;
	localparam int DIV_W = 8;
	localparam int LIMIT_W = 16;
	localparam int SEL_W = 2;
	localparam int PIN_N = 4;
	// Window field codes with fractional offsets, limits in half periods
	localparam logic [EXP_W-1:0] EXP_HALF = 3'h0;
	localparam logic [EXP_W-1:0] EXP_ONE_HALF = 3'h1;
	localparam logic [LIMIT_W-1:0] HALF_LIMIT = 16'h0001;
	localparam logic [LIMIT_W-1:0] ONE_HALF_LIMIT = 16'h0003;
	localparam logic [LIMIT_W-1:0] LIMIT_MAX = 16'hffff;
	// Reset values
	localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
	localparam logic [CNT_W-1:0] HOLDOFF_RESET = 8'h00;
	// Hold-off tick divider default, in ref_clk cycles
	localparam int unsigned HOLDOFF_DIV_DEFAULT = 131072;

	typedef enum logic [1:0] {
		ST_TRACK = 2'b00,
		ST_HOLD = 2'b01,
		ST_RESUME = 2'b11
	} hold_state_t;

	// Synchronised pin bundle
	typedef struct packed {
		logic ref_in;
		logic fb_in;
		logic unit_in;
		logic synth_lock;
	} pins_t;

	// Candidate reference from the priority logic
	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic valid;
	} candidate_t;

	// Lock window configuration
	typedef struct packed {
		logic [EXP_W-1:0] window_start_exponent;
		logic [EXP_W-1:0] window_end_exponent;
		logic synth_bypass_sel;
		logic [DIV_W-1:0] second_feedback_divider;
	} window_cfg_t;
endpackage

// [lock_window_detect.sv]
`timescale 1ns/1ps
module lock_window_detect (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Synchronised levels
	input wire logic ref_s,
	input wire logic fb_s,
	input wire logic unit_s,
	// Configuration
	input wire holdover_pkg::window_cfg_t cfg,
	// Status
	output logic unlocked
);
	import holdover_pkg::*;

	function automatic logic [LIMIT_W-1:0] half_units(input logic [EXP_W-1:0] k);
		logic [LIMIT_W-1:0] span;
		span = LIMIT_W'((32'h1 << k) - 32'h1);
		if (k == EXP_HALF)
			return HALF_LIMIT;
		else if (k == EXP_ONE_HALF)
			return ONE_HALF_LIMIT;
		else
			return LIMIT_W'(span << 1);
	endfunction

	logic ref_prev_reg, fb_prev_reg, unit_prev_reg;
	logic [LIMIT_W-1:0] start_cnt_reg, end_cnt_reg;
	logic armed_reg, pending_reg, unlocked_reg;

	wire ref_rise = ref_s & ~ref_prev_reg;
	wire ref_edge = ref_s ^ ref_prev_reg;
	wire fb_rise = fb_s & ~fb_prev_reg;
	wire unit_edge = unit_s ^ unit_prev_reg;
	wire [LIMIT_W-1:0] start_lim = half_units(cfg.window_start_exponent); // see [RQ10] [RQ11] [RQ13]
	wire [LIMIT_W-1:0] end_base = half_units(cfg.window_end_exponent);
	wire [2*LIMIT_W-1:0] end_prod = end_base * {{(2*LIMIT_W-DIV_W){1'b0}}, cfg.second_feedback_divider};
	wire [LIMIT_W-1:0] end_lim = cfg.synth_bypass_sel ? end_prod[LIMIT_W-1:0] : end_base; // see [RQ12]
	// Feedback late after t0 but inside the end offset
	wire late_ok = fb_rise & ~armed_reg & (end_cnt_reg <= end_lim); // see [RQ9]
	// Reference edge still unpaired after the end offset: feedback missing or too late
	wire late_miss = pending_reg & (end_cnt_reg > end_lim); // see [RQ9]
	// Feedback early: wait for the reference edge within the start offset
	wire fb_early = fb_rise & ~late_ok;
	wire early_ok = armed_reg & ref_rise & (start_cnt_reg < start_lim); // see [RQ9]
	wire early_miss = armed_reg & ((ref_edge & (start_cnt_reg >= start_lim)) | fb_rise);
	wire armed_next = fb_early ? 1'b1 : ((early_ok | early_miss) ? 1'b0 : armed_reg);
	wire pending_next = (ref_rise & ~early_ok) ? 1'b1 :
		((late_ok | late_miss) ? 1'b0 : pending_reg);
	wire unlocked_next = (late_ok | early_ok) ? 1'b0 :
		((early_miss | late_miss) ? 1'b1 : unlocked_reg); // see [RQ7]
	wire [LIMIT_W-1:0] start_cnt_next = fb_rise ? '0 :
		((ref_edge && start_cnt_reg != LIMIT_MAX) ? start_cnt_reg + 1'b1 : start_cnt_reg);
	wire [LIMIT_W-1:0] end_cnt_next = ref_rise ? '0 :
		((unit_edge && end_cnt_reg != LIMIT_MAX) ? end_cnt_reg + 1'b1 : end_cnt_reg);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_prev_reg <= 1'b0;
			fb_prev_reg <= 1'b0;
			unit_prev_reg <= 1'b0;
			start_cnt_reg <= '0;
			end_cnt_reg <= '0;
			armed_reg <= 1'b0;
			pending_reg <= 1'b0;
			unlocked_reg <= 1'b1;
		end else begin
			ref_prev_reg <= ref_s;
			fb_prev_reg <= fb_s;
			unit_prev_reg <= unit_s;
			start_cnt_reg <= start_cnt_next;
			end_cnt_reg <= end_cnt_next;
			armed_reg <= armed_next;
			pending_reg <= pending_next;
			unlocked_reg <= unlocked_next;
		end
	end

	assign unlocked = unlocked_reg;

	window_miss_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [RQ7]
		early_miss && !late_ok |=> unlocked)
		else $error("window miss did not report loss of lock");
	window_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [RQ9]
		armed_reg && ref_rise && start_cnt_reg < start_lim |=> !unlocked && !armed_reg)
		else $error("early feedback inside window not taken as lock");
	late_miss_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [RQ9]
		late_miss && !early_ok |=> unlocked)
		else $error("missing feedback edge not reported as loss of lock");
endmodule // lock_window_detect

// [ref_holdover_lock_detect.sv]
// What this block does
// [RQ1] Hold-off zero starts reselection, reloads counter
// [RQ2] Recovered active reference kept, valid, relock
// [RQ3] Else validated next input becomes selection
// [RQ4] Write one clears loss flag after recovery
// [RQ5] Nothing valid: stay holdover, ignore clear
// [RQ6] Revertive switching returns only when enabled
// [RQ7] Phase window decides VCXO loss of lock
// [RQ8] VCXO loss: live and sticky status bits
// [RQ9] Feedback edge inside window around reference
// [RQ10] Window fields three bits, 010 to 111
// [RQ11] Offset is two-power-k minus one periods
// [RQ12] Deterministic mode scales end by divider
// [RQ13] Codes 000/001 give half, one-half periods
// [RQ14] Software limits window fields to divider
// [RQ15] Synth loss: live, sticky, lock, interrupt
// [RQ16] Sticky bits set on event, write-one clear
`timescale 1ns/1ps
module ref_holdover_lock_detect #(
	parameter int unsigned HOLDOFF_DIV = holdover_pkg::HOLDOFF_DIV_DEFAULT
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Pins from outside the clock domain
	input wire holdover_pkg::pins_t pins_async,
	// Selection control
	input wire logic mode_auto_holdover,
	input wire logic active_los,
	input wire logic active_valid,
	input wire holdover_pkg::candidate_t next_candidate,
	input wire holdover_pkg::candidate_t higher_candidate,
	input wire logic revertive_enable,
	input wire logic [holdover_pkg::CNT_W-1:0] holdoff_start_value,
	input wire holdover_pkg::window_cfg_t window_cfg,
	// Write-one clear strobes
	input wire logic clear_reference_loss,
	input wire logic clear_vcxo_sticky,
	input wire logic clear_synth_sticky,
	// Selection status
	output logic [holdover_pkg::SEL_W-1:0] selected_input_status,
	output logic reference_valid_status,
	output logic reference_loss_sticky,
	output logic holdover_active,
	output logic vcxo_relock,
	output logic revertive_active,
	// Lock status
	output logic vcxo_unlock_live_n,
	output logic vcxo_unlock_sticky_n,
	output logic synth_unlock_live_n,
	output logic synth_unlock_sticky_n,
	output logic lock_out,
	output logic irq_output_n
);
	import holdover_pkg::*;

	localparam int DIVC_W = $clog2(HOLDOFF_DIV + 1);
	localparam logic [DIVC_W-1:0] DIV_LAST = DIVC_W'(HOLDOFF_DIV - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [PIN_N-1:0] sync1_reg, sync2_reg;
	pins_t pins_s;

	generate
		for (genvar i = 0; i < PIN_N; i++) begin : g_sync
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					sync1_reg[i] <= 1'b0;
					sync2_reg[i] <= 1'b0;
				end else begin
					sync1_reg[i] <= pins_async[i];
					sync2_reg[i] <= sync1_reg[i];
				end
			end
		end
	endgenerate

	assign pins_s = sync2_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Hold-off sequencing
	hold_state_t state_reg, state_next;
	logic [DIVC_W-1:0] div_reg;
	logic [CNT_W-1:0] holdoff_reg, holdoff_next;
	logic [SEL_W-1:0] sel_reg, sel_next;
	logic valid_reg, valid_next, loss_reg, loss_next, relock_reg, revert_reg;

	wire in_hold = state_reg == ST_HOLD;
	wire enter_hold = state_reg == ST_TRACK && mode_auto_holdover && active_los;
	wire tick = in_hold && div_reg == DIV_LAST;
	wire expiry = tick && holdoff_reg == HOLDOFF_RESET; // see [RQ1]
	wire keep_active = expiry && active_valid;
	wire take_next = expiry && !active_valid && next_candidate.valid;
	wire revert_ok = state_reg == ST_TRACK && revertive_enable; // see [RQ6]
	wire revert_switch = revert_ok && !enter_hold && higher_candidate.valid;
	wire [DIVC_W-1:0] div_next = (tick || !in_hold) ? '0 : div_reg + 1'b1;

	always_comb begin
		state_next = state_reg;
		holdoff_next = holdoff_reg;
		sel_next = sel_reg;
		valid_next = valid_reg;
		case (state_reg)
			ST_TRACK: begin
				if (enter_hold) begin
					state_next = ST_HOLD;
					holdoff_next = holdoff_start_value;
					valid_next = 1'b0;
				end else if (revert_switch) begin
					sel_next = higher_candidate.sel;
				end
			end
			ST_HOLD: begin
				if (expiry) begin
					holdoff_next = holdoff_start_value; // see [RQ1]
					if (keep_active) begin
						state_next = ST_RESUME; // see [RQ2]
						valid_next = 1'b1;
					end else if (take_next) begin
						state_next = ST_RESUME; // see [RQ3]
						sel_next = next_candidate.sel;
						valid_next = 1'b1;
					end
				end else if (tick) begin
					holdoff_next = holdoff_reg - 1'b1;
				end
			end
			ST_RESUME: begin
				state_next = ST_TRACK;
			end
			default: begin
				state_next = ST_TRACK;
			end
		endcase
	end

	// Loss flag: the loss event wins over a clear; clear ignored in holdover
	always_comb begin
		loss_next = loss_reg;
		if (enter_hold)
			loss_next = 1'b0;
		else if (clear_reference_loss && !in_hold && valid_reg)
			loss_next = 1'b1; // see [RQ4] [RQ5]
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_TRACK;
			div_reg <= '0;
			holdoff_reg <= HOLDOFF_RESET;
			sel_reg <= SEL_RESET;
			valid_reg <= 1'b1;
			loss_reg <= 1'b1;
			relock_reg <= 1'b0;
			revert_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			div_reg <= div_next;
			holdoff_reg <= holdoff_next;
			sel_reg <= sel_next;
			valid_reg <= valid_next;
			loss_reg <= loss_next;
			relock_reg <= keep_active; // see [RQ2]
			revert_reg <= revert_ok;
		end
	end

	assign selected_input_status = sel_reg;
	assign reference_valid_status = valid_reg;
	assign reference_loss_sticky = loss_reg;
	assign vcxo_relock = relock_reg;
	assign revertive_active = revert_reg;

	logic hold_out_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			hold_out_reg <= 1'b0;
		else
			hold_out_reg <= state_next == ST_HOLD;
	end
	assign holdover_active = hold_out_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Lock status
	logic vcxo_unlocked;

	lock_window_detect u_window (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ref_s(pins_s.ref_in),
		.fb_s(pins_s.fb_in),
		.unit_s(pins_s.unit_in),
		.cfg(window_cfg),
		.unlocked(vcxo_unlocked)
	);

	logic vlive_reg, vstick_reg, slive_reg, sstick_reg, lock_reg, irq_reg;
	wire synth_unlocked = !pins_s.synth_lock;
	// Event wins over the write-one clear
	wire vstick_next = vcxo_unlocked ? 1'b0 : (clear_vcxo_sticky ? 1'b1 : vstick_reg); // see [RQ16]
	wire sstick_next = synth_unlocked ? 1'b0 : (clear_synth_sticky ? 1'b1 : sstick_reg); // see [RQ16]

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			vlive_reg <= 1'b0;
			vstick_reg <= 1'b0;
			slive_reg <= 1'b0;
			sstick_reg <= 1'b0;
			lock_reg <= 1'b0;
			irq_reg <= 1'b1;
		end else begin
			vlive_reg <= !vcxo_unlocked; // see [RQ8]
			vstick_reg <= vstick_next; // see [RQ8]
			slive_reg <= !synth_unlocked; // see [RQ15]
			sstick_reg <= sstick_next; // see [RQ15]
			lock_reg <= !vcxo_unlocked && !synth_unlocked;
			irq_reg <= vstick_next && sstick_next; // see [RQ15]
		end
	end

	assign vcxo_unlock_live_n = vlive_reg;
	assign vcxo_unlock_sticky_n = vstick_reg;
	assign synth_unlock_live_n = slive_reg;
	assign synth_unlock_sticky_n = sstick_reg;
	assign lock_out = lock_reg;
	assign irq_output_n = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	reload_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [RQ1]
		expiry |=> holdoff_reg == $past(holdoff_start_value))
		else $error("hold-off counter not reloaded at expiry");
	keep_active_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [RQ2]
		keep_active |=> $stable(selected_input_status) && valid_reg ##1 !holdover_active)
		else $error("recovered reference not kept");
	take_next_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [RQ3]
		take_next |=> sel_reg == $past(next_candidate.sel) && valid_reg)
		else $error("next priority input not selected");
	loss_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [RQ4]
		clear_reference_loss && state_reg == ST_TRACK && valid_reg && !enter_hold |=> loss_reg)
		else $error("reference loss flag not cleared");
	no_valid_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [RQ5]
		expiry && !active_valid && !next_candidate.valid |=> in_hold && !valid_reg && !loss_reg
		&& $stable(sel_reg))
		else $error("holdover left with no valid input");
	revert_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [RQ6]
		revertive_active |-> $past(revertive_enable) && $past(state_reg) == ST_TRACK)
		else $error("revertive switching active outside tracking");
	vcxo_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [RQ8]
		!vcxo_unlock_live_n |-> !vcxo_unlock_sticky_n)
		else $error("vcxo sticky not set with live loss");
	synth_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [RQ15]
		synth_unlocked |=> !synth_unlock_sticky_n && !irq_output_n)
		else $error("synth loss not latched or interrupt not raised");
endmodule // ref_holdover_lock_detect

// [test_ref_holdover_lock_detect.sv]
`timescale 1ns/1ps
module test_ref_holdover_lock_detect;
	import holdover_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic mode_ah = 1'b0;
	logic act_los = 1'b0;
	logic act_valid = 1'b0;
	logic rev_en = 1'b0;
	logic synth_lk = 1'b0;
	logic fb_on = 1'b1;
	candidate_t nxt = '0;
	candidate_t hi = '0;
	window_cfg_t cfg = '0;
	logic [2:0] clr = '0;
	logic [4:0] cnt = '0;
	logic [4:0] dly = 5'h0c;
	pins_t pins;
	logic [SEL_W-1:0] sel;
	logic valid, loss, hold, relock, rev_act, v_live_n, v_stk_n, s_live_n, s_stk_n, lock_o, irq_n;
	logic [7:0] obs;
	int bad_count = 0;
	int n_checks = 0;

	always #12.5 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	// Pin stimulus: ref period 32 cycles, feedback delayed by dly
	always_ff @(posedge ref_clk) cnt <= cnt + 5'h01;
	assign pins = '{ref_in: cnt < 5'h10, fb_in: fb_on && ((cnt - dly) < 5'h10),
		unit_in: cnt[2], synth_lock: synth_lk};
	assign obs = {hold, valid, irq_n, lock_o, s_stk_n, s_live_n, v_stk_n, v_live_n};

	ref_holdover_lock_detect #(.HOLDOFF_DIV(4)) i_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .pins_async(pins),
		.mode_auto_holdover(mode_ah), .active_los(act_los), .active_valid(act_valid),
		.next_candidate(nxt), .higher_candidate(hi), .revertive_enable(rev_en),
		.holdoff_start_value(8'h02), .window_cfg(cfg),
		.clear_reference_loss(clr[0]), .clear_vcxo_sticky(clr[1]), .clear_synth_sticky(clr[2]),
		.selected_input_status(sel), .reference_valid_status(valid),
		.reference_loss_sticky(loss), .holdover_active(hold), .vcxo_relock(relock),
		.revertive_active(rev_act), .vcxo_unlock_live_n(v_live_n),
		.vcxo_unlock_sticky_n(v_stk_n), .synth_unlock_live_n(s_live_n),
		.synth_unlock_sticky_n(s_stk_n), .lock_out(lock_o), .irq_output_n(irq_n)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wait_bit(input int b, input logic v, input string nm);
		int i;
		for (i = 0; i < 400 && obs[b] !== v; i++) tick(1);
		chk(nm, {7'h00, v}, {7'h00, obs[b]});
		if (obs[b] !== v) summarize();
	endtask

	task automatic clear(input int b);
		@(posedge ref_clk) clr[b] <= 1'b1;
		@(posedge ref_clk) clr[b] <= 1'b0;
		tick(1);
	endtask

	task automatic set_cfg(input logic [2:0] s, input logic [2:0] e, input logic b,
		input logic [7:0] d);
		@(posedge ref_clk) cfg <= '{window_start_exponent: s, window_end_exponent: e,
			synth_bypass_sel: b, second_feedback_divider: d};
	endtask

	task automatic los_pulse();
		@(posedge ref_clk) act_los <= 1'b1;
		@(posedge ref_clk) act_los <= 1'b0;
		tick(1);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		tick(16);
		chk("sel", {6'h00, SEL_RESET}, {6'h00, sel});
		chk("valid_loss_hold", 8'h06, {5'h00, valid, loss, hold});
		chk("relock", 8'h00, {7'h00, relock});
		chk("irq_n", 8'h01, {7'h00, irq_n});
		@(posedge ref_clk) rst_n <= 1'b1;
		tick(2);
		$display("test reset done");
	endtask

	task automatic t_window();
		set_cfg(3'h2, 3'h2, 1'b0, 8'h01);
		wait_bit(0, 1'b1, "vcxo_live_n");
		tick(64);
		clear(1);
		chk("vcxo_sticky_n", 8'h01, {7'h00, v_stk_n});
		set_cfg(EXP_HALF, EXP_HALF, 1'b0, 8'h01);
		wait_bit(0, 1'b0, "vcxo_live_n");
		chk("vcxo_sticky_n", 8'h00, {7'h00, v_stk_n});
		set_cfg(EXP_HALF, EXP_HALF, 1'b1, 8'h04);
		wait_bit(0, 1'b1, "vcxo_live_n");
		set_cfg(EXP_HALF, EXP_HALF, 1'b0, 8'h01);
		wait_bit(0, 1'b0, "vcxo_live_n");
		set_cfg(3'h2, 3'h2, 1'b0, 8'h01);
		wait_bit(0, 1'b1, "vcxo_live_n");
		tick(40);
		chk("vcxo_sticky_n", 8'h00, {7'h00, v_stk_n});
		clear(1);
		chk("vcxo_sticky_n", 8'h01, {7'h00, v_stk_n});
		$display("test window done");
	endtask

	task automatic t_synth();
		@(posedge ref_clk) synth_lk <= 1'b1;
		wait_bit(2, 1'b1, "synth_live_n");
		clear(2);
		chk("sticky_irq_lock", 8'h07, {5'h00, s_stk_n, irq_n, lock_o});
		@(posedge ref_clk) synth_lk <= 1'b0;
		wait_bit(2, 1'b0, "synth_live_n");
		tick(1);
		chk("sticky_irq_lock", 8'h00, {5'h00, s_stk_n, irq_n, lock_o});
		@(posedge ref_clk) synth_lk <= 1'b1;
		wait_bit(2, 1'b1, "synth_live_n");
		tick(8);
		chk("synth_sticky_n", 8'h00, {7'h00, s_stk_n});
		clear(2);
		chk("synth_sticky_n", 8'h01, {7'h00, s_stk_n});
		$display("test synth done");
	endtask

	task automatic t_hold_none();
		@(posedge ref_clk) mode_ah <= 1'b1;
		los_pulse();
		chk("hold_valid_loss", 8'h04, {5'h00, hold, valid, loss});
		tick(50);
		chk("hold_valid", 8'h02, {6'h00, hold, valid});
		clear(0);
		chk("loss", 8'h00, {7'h00, loss});
		chk("sel", 8'h00, {6'h00, sel});
		@(posedge ref_clk) nxt <= '{sel: 2'h2, valid: 1'b1};
		wait_bit(6, 1'b1, "valid");
		chk("sel_hold", 8'h04, {5'h00, sel, hold});
		@(posedge ref_clk) nxt <= '0;
		clear(0);
		chk("loss", 8'h01, {7'h00, loss});
		$display("test hold_none done");
	endtask

	task automatic t_hold_keep();
		int n;
		los_pulse();
		@(posedge ref_clk) act_valid <= 1'b1;
		for (n = 0; n < 100 && valid !== 1'b1; n++) tick(1);
		chk("expiry_window", 8'h01, {7'h00, n >= 8 && n <= 18});
		if (valid !== 1'b1) summarize();
		chk("sel_hold_relock", 8'h09, {5'h00, sel, hold, relock});
		tick(1);
		chk("relock", 8'h00, {7'h00, relock});
		@(posedge ref_clk) act_valid <= 1'b0;
		clear(0);
		chk("loss", 8'h01, {7'h00, loss});
		$display("test hold_keep done");
	endtask

	task automatic t_revert();
		@(posedge ref_clk) hi <= '{sel: 2'h3, valid: 1'b1};
		tick(10);
		chk("sel_rev", 8'h04, {5'h00, sel, rev_act});
		@(posedge ref_clk) rev_en <= 1'b1;
		tick(4);
		chk("sel_rev", 8'h07, {5'h00, sel, rev_act});
		@(posedge ref_clk) rev_en <= 1'b0;
		hi <= '0;
		$display("test revert done");
	endtask

	task automatic t_fb_stop();
		@(posedge ref_clk) fb_on <= 1'b0;
		wait_bit(0, 1'b0, "vcxo_live_n");
		tick(1);
		chk("sticky_irq", 8'h00, {6'h00, v_stk_n, irq_n});
		$display("test fb_stop done");
	endtask

	initial begin
		t_reset();
		t_window();
		t_synth();
		t_hold_none();
		t_hold_keep();
		t_revert();
		t_fb_stop();
		summarize();
	end
endmodule // test_ref_holdover_lock_detect
